/* hdl/trc_pkg.sv */
// constants and state types of the timer reload and capture registers
// Function
// (R01) control bit 4 set enters oscillator capture mode
// (R02) capture: each oscillator falling edge copies the 16-bit count into reload
// (R03) control bit 3 set splits the counter into two 8-bit auto-reload counters
// (R04) in 16-bit mode the counter advances only while run control is 1
// (R05) in split mode run control gates only the high-byte counter
// (R06) in split mode the low-byte counter always counts
// (R07) capture source bit 1 selects oscillator falling edge; 0 is reserved
// (R08) external clock select: 0 system clock / 12, 1 external clock / 8
// (R09) per-byte fast clock selects override with the undivided system clock
// (R10) reload low byte is a read/write register, reset to zero
// (R11) reload high byte is a read/write register, reset to zero
// (R12) counter low byte register shows the low byte of the count
// (R13) 16-bit overflow loads the reload value and sets the high overflow flag
// (R14) overflow flags are cleared only by software writing the control register
// (R15) split overflow reloads each byte from its own reload byte
// (R16) divided external clock gives one system-clock pulse per eight rising edges
package trc_pkg;
  // *****************************************************************
  // register map
  // *****************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // *****************************************************************
  // control bit positions
  // *****************************************************************
  localparam int BIT_HIGH_OVERFLOW = 7;
  localparam int BIT_LOW_OVERFLOW = 6;
  localparam int BIT_LOW_INT_ENABLE = 5;
  localparam int BIT_OSC_CAPTURE_ENABLE = 4;
  localparam int BIT_SPLIT_MODE_ENABLE = 3;
  localparam int BIT_RUN_CONTROL = 2;
  localparam int BIT_CAPTURE_SOURCE_SELECT = 1;
  localparam int BIT_EXTERNAL_CLOCK_SELECT = 0;
  // *****************************************************************
  // timebase counts
  // *****************************************************************
  localparam logic [3:0] SYS_DIV_LAST = 4'hB;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
  // *****************************************************************
  // state types
  // *****************************************************************
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } trc_sync_type;
  typedef struct packed {
    logic [3:0] div_count;
    logic [2:0] ext_count;
    logic ext_tick;
    logic [15:0] count;
    logic [15:0] reload;
    logic [7:0] control;
    logic [7:0] rdata;
    logic irq;
  } trc_state_type;
endpackage

/* hdl/trc_edge_sync.sv */
// three-stage synchroniser with agreed-level edge detection
`timescale 1ns/1ps
module trc_edge_sync
(
  input wire logic clk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic din, // asynchronous input
  output logic rise, // one-cycle pulse on a rising edge
  output logic fall // one-cycle pulse on a falling edge
);
  trc_pkg::trc_sync_type st;
  trc_pkg::trc_sync_type next_st;

  // a change only counts once the second and third stages agree
  always_comb
  begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if ((st.s2 == st.s3) && (st.s3 != st.level))
    begin
      next_st.level = st.s3;
      next_st.rise = st.s3;
      next_st.fall = !st.s3;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign rise = st.rise;
  assign fall = st.fall;

  single_rise_a: assert property (@(posedge clk) disable iff (!resetn)
    rise |=> !rise) else $error("edge pulse lasted more than one cycle");
endmodule

/* hdl/trc_timer.sv */
// timer counter with auto-reload, split mode and oscillator capture
`timescale 1ns/1ps
module trc_timer
(
  input wire logic SYS_CLK, // system clock, 125 MHz
  input wire logic RESETN, // synchronous reset, active low
  input wire logic [7:0] SFR_ADDR, // register address
  input wire logic SFR_WR, // write strobe, one cycle
  input wire logic [7:0] SFR_WDATA, // write data
  output logic [7:0] SFR_RDATA, // read data, one cycle after the address
  input wire logic EXT_CLK, // external oscillator clock
  input wire logic LOW_FREQ_OSC, // low-frequency oscillator output
  input wire logic HIGH_BYTE_FAST_CLOCK_SELECT, // high byte runs on the system clock in split mode
  input wire logic LOW_BYTE_FAST_CLOCK_SELECT, // low byte runs on the system clock
  input wire logic TIMER_INT_ENABLE, // timer interrupts enabled
  output logic INT_REQUEST, // interrupt request, level while the high overflow flag, or the low flag with its enable bit, is set, one-cycle pulse on a capture
  output logic [7:0] COUNTER_HIGH_BYTE // current high byte of the count
);
  trc_pkg::trc_state_type st;
  trc_pkg::trc_state_type next_st;
  logic ext_rise;
  logic osc_fall;
  logic div_tick;
  logic slow_tick;
  logic high_tick;
  logic low_tick;
  logic split_mode_enable;
  logic run_control;
  logic capture_now;
  logic wr_control;
  logic wr_reload_low;
  logic wr_reload_high;
  logic wr_count_low;
  logic set_high;
  logic set_low;

  // *****************************************************************
  // input synchronisers
  // *****************************************************************
  trc_edge_sync ext_sync
  (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .din(EXT_CLK),
    .rise(ext_rise),
    .fall()
  );

  trc_edge_sync osc_sync
  (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .din(LOW_FREQ_OSC),
    .rise(),
    .fall(osc_fall)
  );

  // *****************************************************************
  // timebase and decode
  // *****************************************************************
  always_comb
  begin
    div_tick = (st.div_count == trc_pkg::SYS_DIV_LAST);
    slow_tick = st.control[trc_pkg::BIT_EXTERNAL_CLOCK_SELECT] ? st.ext_tick : div_tick; // R08
    high_tick = HIGH_BYTE_FAST_CLOCK_SELECT | slow_tick; // R09
    low_tick = LOW_BYTE_FAST_CLOCK_SELECT | slow_tick; // R09
    split_mode_enable = st.control[trc_pkg::BIT_SPLIT_MODE_ENABLE];
    run_control = st.control[trc_pkg::BIT_RUN_CONTROL];
    // reserved source value never captures
    capture_now = osc_fall && st.control[trc_pkg::BIT_OSC_CAPTURE_ENABLE] // R01
      && st.control[trc_pkg::BIT_CAPTURE_SOURCE_SELECT]; // R07
    wr_control = 1'b0;
    wr_reload_low = 1'b0;
    wr_reload_high = 1'b0;
    wr_count_low = 1'b0;
    if (SFR_WR && (SFR_ADDR == trc_pkg::ADDR_CONTROL))
      wr_control = 1'b1;
    else if (SFR_WR && (SFR_ADDR == trc_pkg::ADDR_RELOAD_LOW))
      wr_reload_low = 1'b1;
    else if (SFR_WR && (SFR_ADDR == trc_pkg::ADDR_RELOAD_HIGH))
      wr_reload_high = 1'b1;
    else if (SFR_WR && (SFR_ADDR == trc_pkg::ADDR_COUNT_LOW))
      wr_count_low = 1'b1;
  end

  // *****************************************************************
  // next state
  // *****************************************************************
  always_comb
  begin
    next_st = st;
    set_high = 1'b0;
    set_low = 1'b0;
    next_st.div_count = div_tick ? 4'h0 : 4'(st.div_count + 4'h1);
    next_st.ext_tick = 1'b0;
    if (ext_rise)
    begin
      next_st.ext_count = 3'(st.ext_count + 3'h1);
      next_st.ext_tick = (st.ext_count == trc_pkg::EXT_DIV_LAST); // R16
    end
    if (!split_mode_enable)
    begin
      if (run_control && low_tick) // R04
      begin
        if (st.count == trc_pkg::WORD_MAX)
        begin
          next_st.count = st.reload; // R13
          set_high = 1'b1;
          set_low = 1'b1;
        end
        else
        begin
          next_st.count = 16'(st.count + 16'h0001);
          set_low = (st.count[7:0] == trc_pkg::BYTE_MAX);
        end
      end
    end
    else
    begin
      if (low_tick) // R03 R06
      begin
        set_low = (st.count[7:0] == trc_pkg::BYTE_MAX);
        next_st.count[7:0] = set_low ? st.reload[7:0] : 8'(st.count[7:0] + 8'h01); // R15
      end
      if (run_control && high_tick) // R05
      begin
        set_high = (st.count[15:8] == trc_pkg::BYTE_MAX);
        next_st.count[15:8] = set_high ? st.reload[15:8] : 8'(st.count[15:8] + 8'h01); // R15
      end
    end
    if (wr_count_low)
      next_st.count[7:0] = SFR_WDATA;
    if (wr_reload_low)
      next_st.reload[7:0] = SFR_WDATA; // R10
    if (wr_reload_high)
      next_st.reload[15:8] = SFR_WDATA; // R11
    // the capture outranks a same-cycle software write of the reload bytes
    if (capture_now)
      next_st.reload = st.count; // R02
    if (wr_control)
      next_st.control = SFR_WDATA;
    // a hardware set outranks a same-cycle software clear
    if (set_high)
      next_st.control[trc_pkg::BIT_HIGH_OVERFLOW] = 1'b1; // R14
    if (set_low)
      next_st.control[trc_pkg::BIT_LOW_OVERFLOW] = 1'b1; // R14
    next_st.irq = TIMER_INT_ENABLE && (capture_now
      || next_st.control[trc_pkg::BIT_HIGH_OVERFLOW]
      || (next_st.control[trc_pkg::BIT_LOW_INT_ENABLE]
      && next_st.control[trc_pkg::BIT_LOW_OVERFLOW])); // R02
    next_st.rdata = trc_pkg::RESET_BYTE;
    if (SFR_ADDR == trc_pkg::ADDR_CONTROL)
      next_st.rdata = st.control;
    else if (SFR_ADDR == trc_pkg::ADDR_RELOAD_LOW)
      next_st.rdata = st.reload[7:0]; // R10
    else if (SFR_ADDR == trc_pkg::ADDR_RELOAD_HIGH)
      next_st.rdata = st.reload[15:8]; // R11
    else if (SFR_ADDR == trc_pkg::ADDR_COUNT_LOW)
      next_st.rdata = st.count[7:0]; // R12
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      st.div_count <= 4'h0;
      st.ext_count <= 3'h0;
      st.ext_tick <= 1'b0;
      st.count <= trc_pkg::RESET_WORD;
      st.reload <= trc_pkg::RESET_WORD;
      st.control <= trc_pkg::RESET_BYTE;
      st.rdata <= trc_pkg::RESET_BYTE;
      st.irq <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign SFR_RDATA = st.rdata;
  assign INT_REQUEST = st.irq;
  assign COUNTER_HIGH_BYTE = st.count[15:8];

  // *****************************************************************
  // assertions
  // *****************************************************************
  capture_copy_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R02
    capture_now |=> (st.reload == $past(st.count)))
    else $error("capture did not copy the count into reload");

  capture_off_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R01
    (!st.control[trc_pkg::BIT_OSC_CAPTURE_ENABLE] && !wr_reload_low && !wr_reload_high)
    |=> $stable(st.reload))
    else $error("reload changed with capture disabled");

  reserved_source_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R07
    (!st.control[trc_pkg::BIT_CAPTURE_SOURCE_SELECT] && !wr_reload_low && !wr_reload_high)
    |=> $stable(st.reload))
    else $error("reload changed with reserved capture source");

  run_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R04
    (!split_mode_enable && !run_control && !wr_count_low) |=> $stable(st.count))
    else $error("16-bit counter moved while stopped");

  wrap_word_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R13
    (!split_mode_enable && run_control && low_tick && !wr_count_low
    && (st.count == trc_pkg::WORD_MAX))
    |=> (st.count == $past(st.reload)) && st.control[trc_pkg::BIT_HIGH_OVERFLOW])
    else $error("16-bit overflow did not reload or flag");

  high_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R05
    (split_mode_enable && !run_control) |=> (st.count[15:8] == $past(st.count[15:8])))
    else $error("split high byte moved while stopped");

  low_free_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R06 R03
    (split_mode_enable && !run_control && low_tick && !wr_count_low
    && (st.count[7:0] != trc_pkg::BYTE_MAX))
    |=> (st.count[7:0] == 8'($past(st.count[7:0]) + 8'h01)))
    else $error("split low byte did not count");

  wrap_byte_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R15
    (split_mode_enable && low_tick && !wr_count_low && (st.count[7:0] == trc_pkg::BYTE_MAX))
    |=> (st.count[7:0] == $past(st.reload[7:0])) && st.control[trc_pkg::BIT_LOW_OVERFLOW])
    else $error("split low byte did not reload from its own byte");

  flag_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R14
    (st.control[trc_pkg::BIT_HIGH_OVERFLOW] && !wr_control)
    |=> st.control[trc_pkg::BIT_HIGH_OVERFLOW])
    else $error("overflow flag cleared without a write");

  div_period_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R08
    div_tick |-> ##12 div_tick)
    else $error("divide by twelve period wrong");

  fast_select_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R09
    (!split_mode_enable && run_control && LOW_BYTE_FAST_CLOCK_SELECT && !wr_count_low
    && (st.count != trc_pkg::WORD_MAX))
    |=> (st.count == 16'($past(st.count) + 16'h0001)))
    else $error("fast select did not advance the count every clock");

  ext_pulse_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R16
    st.ext_tick |=> !st.ext_tick)
    else $error("external tick wider than one cycle");

  reload_write_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R10
    (wr_reload_low && !capture_now) |=> (st.reload[7:0] == $past(SFR_WDATA)))
    else $error("reload low byte write lost");

  reload_high_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R11
    (wr_reload_high && !capture_now) |=> (st.reload[15:8] == $past(SFR_WDATA)))
    else $error("reload high byte write lost");

  count_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R12
    (SFR_ADDR == trc_pkg::ADDR_COUNT_LOW) |=> (SFR_RDATA == $past(st.count[7:0])))
    else $error("count low read wrong");
endmodule

/* testbench/trc_timer_tb.sv */
// self-checking testbench for the timer reload and capture registers
`timescale 1ns/1ps
module trc_timer_tb;
  // *****************************************************************
  // stimulus signals and counters
  // *****************************************************************
  logic sys_clk;
  logic resetn;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic ext_clk;
  logic low_frequency_oscillator;
  logic hi_fast;
  logic lo_fast;
  logic int_en;
  logic int_req;
  logic [7:0] count_high;
  logic [7:0] v;
  logic [7:0] h;
  int err_count;
  int checks;
  int i;

  trc_timer trc_timer_i
  (
    .SYS_CLK(sys_clk),
    .RESETN(resetn),
    .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr),
    .SFR_WDATA(sfr_wdata),
    .SFR_RDATA(sfr_rdata),
    .EXT_CLK(ext_clk),
    .LOW_FREQ_OSC(low_frequency_oscillator),
    .HIGH_BYTE_FAST_CLOCK_SELECT(hi_fast),
    .LOW_BYTE_FAST_CLOCK_SELECT(lo_fast),
    .TIMER_INT_ENABLE(int_en),
    .INT_REQUEST(int_req),
    .COUNTER_HIGH_BYTE(count_high)
  );

  always #4 sys_clk = ~sys_clk;
  // a half period of three system clocks keeps its edges off the sampling edge
  always #24 ext_clk = ~ext_clk;

  // *****************************************************************
  // access and compare tasks
  // *****************************************************************
  task close_out;
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi, input string m);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      $display("wrong value at %0t: %s got %h", $time, m, got);
      err_count++;
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    sfr_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi, input string m);
    @(posedge sys_clk);
    #1;
    sfr_addr = a;
    @(posedge sys_clk);
    #1;
    chk(sfr_rdata, lo, hi, m);
  endtask

  task idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task give_up(input int n);
    if (i == n)
    begin
      err_count++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out();
    end
  endtask

  // *****************************************************************
  // main sequence
  // *****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    ext_clk = 1'b0;
    low_frequency_oscillator = 1'b1;
    hi_fast = 1'b0;
    lo_fast = 1'b0;
    int_en = 1'b0;
    err_count = 0;
    checks = 0;
    // three edges clear every synchroniser stage as well
    repeat (3) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    rd(trc_pkg::ADDR_CONTROL, 8'h00, 8'h00, "control reset");
    rd(trc_pkg::ADDR_RELOAD_LOW, 8'h00, 8'h00, "reload low reset");
    rd(trc_pkg::ADDR_RELOAD_HIGH, 8'h00, 8'h00, "reload high reset");
    rd(trc_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00, "count low reset");
    rd(8'hC9, 8'h00, 8'h00, "unmapped read");
    wr(trc_pkg::ADDR_RELOAD_LOW, 8'h55);
    rd(trc_pkg::ADDR_RELOAD_LOW, 8'h55, 8'h55, "reload low rw");
    wr(trc_pkg::ADDR_RELOAD_HIGH, 8'hAA);
    rd(trc_pkg::ADDR_RELOAD_HIGH, 8'hAA, 8'hAA, "reload high rw");
    lo_fast = 1'b1;
    idle(30);
    rd(trc_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00, "stopped counter moved");
    wr(trc_pkg::ADDR_COUNT_LOW, 8'h3C);
    rd(trc_pkg::ADDR_COUNT_LOW, 8'h3C, 8'h3C, "count low rw");
    // slow timebases: ten ticks each, one tick of slack for synchronising
    lo_fast = 1'b0;
    wr(trc_pkg::ADDR_CONTROL, 8'h04);
    wr(trc_pkg::ADDR_COUNT_LOW, 8'h00);
    idle(120);
    rd(trc_pkg::ADDR_COUNT_LOW, 8'h09, 8'h0B, "divide by 12 rate");
    wr(trc_pkg::ADDR_CONTROL, 8'h05);
    wr(trc_pkg::ADDR_COUNT_LOW, 8'h00);
    idle(500);
    rd(trc_pkg::ADDR_COUNT_LOW, 8'h09, 8'h0B, "external divide by 8 rate");
    lo_fast = 1'b1;
    wr(trc_pkg::ADDR_CONTROL, 8'h04);
    sfr_addr = trc_pkg::ADDR_COUNT_LOW;
    idle(2);
    v = sfr_rdata;
    idle(1);
    chk(sfr_rdata, v + 8'h01, v + 8'h01, "fast count step");
    // 16-bit overflow: the high byte reaches FF after FF00 counts, before the word overflows
    int_en = 1'b1;
    wr(trc_pkg::ADDR_RELOAD_HIGH, 8'hFF);
    wr(trc_pkg::ADDR_RELOAD_LOW, 8'h00);
    for (i = 0; i < 70000 && count_high !== 8'hFF; i++) idle(1);
    give_up(70000);
    wr(trc_pkg::ADDR_CONTROL, 8'h04);
    idle(300);
    rd(trc_pkg::ADDR_CONTROL, 8'hC4, 8'hC4, "overflow flags");
    chk(count_high, 8'hFF, 8'hFF, "word reload");
    chk({7'h00, int_req}, 8'h01, 8'h01, "overflow request");
    wr(trc_pkg::ADDR_CONTROL, 8'hC0);
    h = count_high;
    sfr_addr = trc_pkg::ADDR_COUNT_LOW;
    idle(2);
    v = sfr_rdata;
    idle(40);
    chk(sfr_rdata, v, v, "stopped low byte");
    rd(trc_pkg::ADDR_CONTROL, 8'hC0, 8'hC0, "flags held");
    chk(count_high, h, h, "stopped high byte");
    // split mode with both bytes on the fast clock
    hi_fast = 1'b1;
    wr(trc_pkg::ADDR_RELOAD_HIGH, 8'h80);
    wr(trc_pkg::ADDR_RELOAD_LOW, 8'hF0);
    wr(trc_pkg::ADDR_CONTROL, 8'h08);
    h = count_high;
    idle(300);
    chk(count_high, h, h, "split high ran while stopped");
    rd(trc_pkg::ADDR_COUNT_LOW, 8'hF0, 8'hFF, "split low reload");
    rd(trc_pkg::ADDR_CONTROL, 8'h48, 8'h48, "split low flag");
    wr(trc_pkg::ADDR_CONTROL, 8'h0C);
    idle(300);
    chk(count_high, 8'h80, 8'hFF, "split high reload");
    rd(trc_pkg::ADDR_CONTROL, 8'hCC, 8'hCC, "split flags");
    // capture: first with the enable off, then on
    wr(trc_pkg::ADDR_CONTROL, 8'h02);
    wr(trc_pkg::ADDR_RELOAD_LOW, 8'h5A);
    wr(trc_pkg::ADDR_COUNT_LOW, 8'h00);
    low_frequency_oscillator = 1'b0;
    idle(12);
    rd(trc_pkg::ADDR_RELOAD_LOW, 8'h5A, 8'h5A, "capture while disabled");
    low_frequency_oscillator = 1'b1;
    idle(12);
    h = count_high;
    chk({7'h00, int_req}, 8'h00, 8'h00, "request before capture");
    wr(trc_pkg::ADDR_CONTROL, 8'h16);
    low_frequency_oscillator = 1'b0;
    for (i = 0; i < 12 && int_req !== 1'b1; i++) idle(1);
    give_up(12);
    idle(1);
    chk({7'h00, int_req}, 8'h00, 8'h00, "capture request width");
    rd(trc_pkg::ADDR_RELOAD_LOW, 8'h01, 8'h14, "captured low byte");
    rd(trc_pkg::ADDR_RELOAD_HIGH, h, h, "captured high byte");
    close_out();
  end
endmodule
